// [verilog/nsac_ctrl.v]
// nsac_ctrl: self-access controller for data eeprom and flash program memory
// assumes an apb master on pclk, fuses static, array answers mem_rd in the same cycle
// Overview of operation
// - data memory counts as protected when data_protect_fuse reads zero.
// - while protected only the cpu reaches eeprom; external programmer is refused.
// - flash is rows of 14-bit words; a row is the smallest erase.
// - write or erase only when address lies outside the protected segment.
// - 14-bit write latches are filled only via the data register pair.
// - a row is 32 words, aligned on five zero low address bits.
// - the latch set is 8 words, aligned on three zero low bits.
// - program read uses the second following cycle; that instruction is discarded.
// - read word lands in data registers next cycle and stays there.
// - cpu reads of flash ignore program_protect_fuse.
// - while running, program memory is erased in whole rows only.
// - row_erase_select stays set during an erase and clears on completion.
// - two setup cycles after program_go; software fills them with no_operation.
// - row erase halts the cpu about 2 ms; clocks keep running.
// - cpu resumes at the third instruction after the one that set go; after a flash block write the code resumes at the fourth.
// - read_trigger and program_go are set-only; hardware clears them when done.
// - program_go refused without write_permit; clearing permit does not abort.
// - program_space_select picks flash; clear, the default, picks eeprom.
// - a finished write sets nvm_done_flag; only software clears it.
`timescale 1ns/1ps
`include "nsac_consts.vh"
module nsac_ctrl #(
  parameter ERASE_CYCLES = `NSAC_ERASE_TIME_US * 1000 / `NSAC_CLK_PERIOD_NS,
  parameter WRITE_CYCLES = `NSAC_EEWRITE_TIME_US * 1000 / `NSAC_CLK_PERIOD_NS,
  parameter LATCHES      = 8
) (
  // clock and reset
  input  wire                pclk,
  input  wire                presetn,
  // apb slave
  input  wire [7:0]          paddr,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  // configuration fuses
  input  wire                data_protect_fuse,
  input  wire                program_protect_fuse,
  input  wire [1:0]          self_write_protect,
  // external programmer access to the data eeprom
  input  wire                ext_req,
  output reg                 ext_grant,
  // cpu pipeline control
  output reg                 cpu_halt,
  output reg                 cpu_discard,
  // nonvolatile arrays
  output reg                 mem_prog_space,
  output reg  [14:0]         mem_addr,
  output reg                 mem_rd,
  input  wire [13:0]         mem_rdata,
  output reg                 mem_erase,
  output reg                 mem_write,
  output reg  [7:0]          mem_wbyte,
  output wire [LATCHES*14-1:0] mem_wblock
);

  localparam ST_IDLE   = 3'd0;
  localparam ST_RWAIT  = 3'd1;
  localparam ST_RACC   = 3'd2;
  localparam ST_RCAP   = 3'd3;
  localparam ST_SETUP1 = 3'd4;
  localparam ST_SETUP2 = 3'd5;
  localparam ST_BUSY   = 3'd6;

  // software visible state
  reg [7:0]  addr_low_reg;
  reg [7:0]  addr_high_reg;
  reg [7:0]  data_low_reg;
  reg [5:0]  data_high_reg;
  reg        read_trigger;
  reg        program_go;
  reg        write_permit;
  reg        write_error;
  reg        latch_only;
  reg        row_erase_select;
  reg        config_space_select;
  reg        program_space_select;
  reg        nvm_done_flag;
  reg [1:0]  key_stage;
  reg [2:0]  state;

  // internal strobes
  reg        latch_load;
  reg        latch_blank;
  reg        timer_start;
  reg [19:0] timer_len;
  wire       timer_done;

  wire [14:0] word_addr = {addr_high_reg[6:0], addr_low_reg};
  wire        wr_access = psel & penable & pready & pwrite;
  wire        setup     = psel & ~penable;
  wire        ctl_wr    = wr_access & (paddr == `NSAC_OFF_CONTROL);
  wire        key_wr    = wr_access & (paddr == `NSAC_OFF_UNLOCK_KEY);
  wire        flg_wr    = wr_access & (paddr == `NSAC_OFF_FLAGS);

  // read and go may only be raised by software
  wire sw_read_set = ctl_wr & pwdata[`NSAC_CTL_READ_TRIGGER] & (state == ST_IDLE);
  wire sw_go_set   = ctl_wr & pwdata[`NSAC_CTL_PROGRAM_GO] & (state == ST_IDLE)
                     & write_permit & (key_stage == 2'd2);

  // protected segment test on the targeted flash word
  reg protected_hit;
  always @* begin
    case (self_write_protect)
      2'b11:   protected_hit = 1'b0;
      2'b10:   protected_hit = word_addr < `NSAC_WRP_LIMIT_SMALL;
      2'b01:   protected_hit = word_addr < `NSAC_WRP_LIMIT_HALF;
      default: protected_hit = 1'b1;
    endcase
  end

  // flash ops hit protection only when program space is chosen
  wire op_refused = program_space_select & protected_hit;

  // apb answer: zero wait state, data registered in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= 1'b0;
        case (paddr)
          `NSAC_OFF_ADDR_LOW:   prdata <= {24'h00_0000, addr_low_reg};
          `NSAC_OFF_ADDR_HIGH:  prdata <= {24'h00_0000, addr_high_reg};
          `NSAC_OFF_DATA_LOW:   prdata <= {24'h00_0000, data_low_reg};
          `NSAC_OFF_DATA_HIGH:  prdata <= {26'h000_0000, data_high_reg};
          `NSAC_OFF_CONTROL:    prdata <= {24'h00_0000, program_space_select,
                                           config_space_select, row_erase_select,
                                           latch_only, write_error, write_permit,
                                           program_go, read_trigger};
          `NSAC_OFF_UNLOCK_KEY: prdata <= 32'h0000_0000; // key register reads as zero
          `NSAC_OFF_FLAGS:      prdata <= {29'h0000_0000, cpu_halt,
                                           (state != ST_IDLE), nvm_done_flag};
          `NSAC_OFF_FUSES:      prdata <= {28'h000_0000, self_write_protect,
                                           program_protect_fuse, data_protect_fuse};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // address and data registers; a finished read overwrites the data pair
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_reg  <= 8'h00;
      addr_high_reg <= 8'h00;
      data_low_reg  <= 8'h00;
      data_high_reg <= 6'h00;
    end else begin
      if (wr_access && paddr == `NSAC_OFF_ADDR_LOW)
        addr_low_reg <= pwdata[7:0];
      if (wr_access && paddr == `NSAC_OFF_ADDR_HIGH)
        addr_high_reg <= pwdata[7:0];
      if (state == ST_RCAP) begin
        data_low_reg  <= mem_rdata[7:0];
        data_high_reg <= mem_prog_space ? mem_rdata[13:8] : 6'h00;
      end else begin
        if (wr_access && paddr == `NSAC_OFF_DATA_LOW)
          data_low_reg <= pwdata[7:0];
        if (wr_access && paddr == `NSAC_OFF_DATA_HIGH)
          data_high_reg <= pwdata[5:0];
      end
    end
  end

  // unlock key tracker: 55h then aah arms one go; any other write except a non-go control write disarms
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_stage <= 2'd0;
    end else if (key_wr) begin
      if (pwdata[7:0] == `NSAC_KEY_FIRST)
        key_stage <= 2'd1;
      else if (pwdata[7:0] == `NSAC_KEY_SECOND && key_stage == 2'd1)
        key_stage <= 2'd2;
      else
        key_stage <= 2'd0;
    end else if (wr_access) begin
      key_stage <= sw_go_set ? 2'd0 : (ctl_wr ? key_stage : 2'd0);
    end
  end

  // control bits; hardware clears read and go itself
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_trigger         <= 1'b0;
      program_go           <= 1'b0;
      write_permit         <= 1'b0;
      write_error          <= 1'b0;
      latch_only           <= 1'b0;
      row_erase_select     <= 1'b0;
      config_space_select  <= 1'b0;
      program_space_select <= 1'b0;
    end else begin
      if (ctl_wr) begin
        // permit may drop mid-operation without aborting it
        write_permit <= pwdata[`NSAC_CTL_WRITE_PERMIT];
        write_error  <= pwdata[`NSAC_CTL_WRITE_ERROR];
        if (state == ST_IDLE) begin
          latch_only           <= pwdata[`NSAC_CTL_LATCH_ONLY];
          row_erase_select     <= pwdata[`NSAC_CTL_ROW_ERASE];
          config_space_select  <= pwdata[`NSAC_CTL_CONFIG_SPACE];
          program_space_select <= pwdata[`NSAC_CTL_PROG_SPACE];
        end
      end
      if (sw_read_set)
        read_trigger <= 1'b1;
      if (sw_go_set)
        program_go <= 1'b1;
      if (state == ST_RCAP)
        read_trigger <= 1'b0;
      if (state == ST_SETUP2 && op_refused) begin
        program_go  <= 1'b0;
        write_error <= 1'b1;
      end
      if (timer_done) begin
        program_go <= 1'b0;
        if (row_erase_select)
          row_erase_select <= 1'b0;
      end
      if (state == ST_BUSY && latch_only && !row_erase_select && program_space_select)
        program_go <= 1'b0;
    end
  end

  // done flag: software writes one to clear, a new completion wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      nvm_done_flag <= 1'b0;
    else if (timer_done)
      nvm_done_flag <= 1'b1;
    else if (flg_wr && pwdata[`NSAC_FLG_DONE])
      nvm_done_flag <= 1'b0;
  end

  // sequencer for reads, latch loads, erases and writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_IDLE;
      mem_rd      <= 1'b0;
      mem_erase   <= 1'b0;
      mem_write   <= 1'b0;
      cpu_discard <= 1'b0;
      cpu_halt    <= 1'b0;
      latch_load  <= 1'b0;
      latch_blank <= 1'b0;
      timer_start <= 1'b0;
      timer_len   <= 20'h00000;
      mem_addr    <= 15'h0000;
      mem_wbyte   <= 8'h00;
      mem_prog_space <= 1'b0;
    end else begin
      mem_rd      <= 1'b0;
      mem_erase   <= 1'b0;
      mem_write   <= 1'b0;
      cpu_discard <= 1'b0;
      latch_load  <= 1'b0;
      latch_blank <= 1'b0;
      timer_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          mem_prog_space <= program_space_select;
          if (sw_read_set)
            state <= program_space_select ? ST_RWAIT : ST_RACC;
          else if (sw_go_set)
            state <= ST_SETUP1;
        end
        ST_RWAIT: state <= ST_RACC;
        ST_RACC: begin
          // flash: second cycle after the trigger, its instruction dropped; eeprom: first cycle, nothing dropped
          mem_rd      <= 1'b1;
          cpu_discard <= program_space_select;
          mem_addr    <= program_space_select ? word_addr : {7'h00, addr_low_reg};
          state       <= ST_RCAP;
        end
        ST_RCAP: state <= ST_IDLE;
        ST_SETUP1: state <= ST_SETUP2;
        ST_SETUP2: begin
          if (op_refused) begin
            state <= ST_IDLE;
          end else if (program_space_select && row_erase_select) begin
            // whole row only, low five address bits forced to zero
            mem_addr    <= {word_addr[14:5], 5'b00000};
            mem_erase   <= 1'b1;
            cpu_halt    <= 1'b1;
            timer_len   <= ERASE_CYCLES[19:0];
            timer_start <= 1'b1;
            state       <= ST_BUSY;
          end else if (program_space_select) begin
            latch_load <= 1'b1;
            state      <= ST_BUSY;
          end else begin
            mem_addr    <= {7'h00, addr_low_reg};
            mem_wbyte   <= data_low_reg;
            mem_write   <= 1'b1;
            timer_len   <= WRITE_CYCLES[19:0];
            timer_start <= 1'b1;
            state       <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (program_space_select && !row_erase_select && !mem_erase && !cpu_halt
              && !timer_start && !mem_write) begin
            if (latch_only) begin
              state <= ST_IDLE; // latch load only, no stall
            end else begin
              mem_addr    <= {word_addr[14:3], 3'b000};
              mem_write   <= 1'b1;
              cpu_halt    <= 1'b1;
              timer_len   <= ERASE_CYCLES[19:0];
              timer_start <= 1'b1;
            end
          end else if (timer_done) begin
            // release lands on the third instruction after go for a row erase, the fourth for a flash block write
            cpu_halt    <= 1'b0;
            latch_blank <= program_space_select & ~row_erase_select;
            state       <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // programmer may reach the eeprom only when data is unprotected
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ext_grant <= 1'b0;
    else
      ext_grant <= ext_req & data_protect_fuse;
  end

  nsac_latches #(
    .WORDS (LATCHES),
    .IDXW  (`NSAC_LATCH_BITS)
  ) u_latches (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (latch_load),
    .idx     (addr_low_reg[`NSAC_LATCH_BITS-1:0]),
    .din     ({data_high_reg, data_low_reg}),
    .blank   (latch_blank),
    .block   (mem_wblock)
  );

  nsac_timer #(
    .W (20)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (timer_start),
    .len     (timer_len),
    .done    (timer_done)
  );

endmodule

// [verilog/nsac_consts.vh]
// constants of the nonvolatile self-access controller: offsets, fields, reset values, timing
// assumes inclusion by bare name from the design files
`ifndef NSAC_CONSTS_VH
`define NSAC_CONSTS_VH

// apb register byte offsets
`define NSAC_OFF_ADDR_LOW    8'h00
`define NSAC_OFF_ADDR_HIGH   8'h04
`define NSAC_OFF_DATA_LOW    8'h08
`define NSAC_OFF_DATA_HIGH   8'h0c
`define NSAC_OFF_CONTROL     8'h10
`define NSAC_OFF_UNLOCK_KEY  8'h14
`define NSAC_OFF_FLAGS       8'h18
`define NSAC_OFF_FUSES       8'h1c

// nvm_control_reg bit positions
`define NSAC_CTL_READ_TRIGGER 0
`define NSAC_CTL_PROGRAM_GO   1
`define NSAC_CTL_WRITE_PERMIT 2
`define NSAC_CTL_WRITE_ERROR  3
`define NSAC_CTL_LATCH_ONLY   4
`define NSAC_CTL_ROW_ERASE    5
`define NSAC_CTL_CONFIG_SPACE 6
`define NSAC_CTL_PROG_SPACE   7

// flag register bit positions
`define NSAC_FLG_DONE 0
`define NSAC_FLG_BUSY 1
`define NSAC_FLG_HALT 2

// reset values and unlock keys
`define NSAC_CONTROL_RESET 8'h00
`define NSAC_KEY_FIRST     8'h55
`define NSAC_KEY_SECOND    8'haa
`define NSAC_LATCH_BLANK   14'h3fff

// array organisation
`define NSAC_WORD_BITS  14
`define NSAC_ROW_BITS   5
`define NSAC_LATCH_BITS 3

// self write protect segment limits (first unprotected word address)
`define NSAC_WRP_LIMIT_HALF  15'h4000
`define NSAC_WRP_LIMIT_SMALL 15'h0200

// timing
`define NSAC_CLK_PERIOD_NS   10
`define NSAC_ERASE_TIME_US   2000
`define NSAC_EEWRITE_TIME_US 2000

`endif

// [verilog/nsac_timer.v]
// nsac_timer: down counter that times an erase or write in clock cycles
// assumes start is a one-cycle pulse and len is at least one
`timescale 1ns/1ps
module nsac_timer #(
  parameter W = 20
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // control
  input  wire         start,
  input  wire [W-1:0] len,
  output reg          done
);

  reg [W-1:0] count;
  reg         running;

  // count down from len, pulse done on the last cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= {W{1'b0}};
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count   <= len;
        running <= 1'b1;
      end else if (running) begin
        if (count <= {{(W-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count <= count - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// [verilog/nsac_latches.v]
// nsac_latches: bank of 14-bit flash write latches, not visible to software
// assumes load and blank are never asserted together by the controller
`timescale 1ns/1ps
`include "nsac_consts.vh"
module nsac_latches #(
  parameter WORDS = 8,
  parameter IDXW  = 3
) (
  // clock and reset
  input  wire                    pclk,
  input  wire                    presetn,
  // load one word, or blank the whole set
  input  wire                    load,
  input  wire [IDXW-1:0]         idx,
  input  wire [13:0]             din,
  input  wire                    blank,
  // whole set, word 0 in the low bits
  output wire [WORDS*14-1:0]     block
);

  reg [13:0] word [0:WORDS-1];
  integer    i;

  // blank state is all ones so untouched words leave flash cells erased
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < WORDS; i = i + 1)
        word[i] <= `NSAC_LATCH_BLANK;
    end else if (blank) begin
      for (i = 0; i < WORDS; i = i + 1)
        word[i] <= `NSAC_LATCH_BLANK;
    end else if (load) begin
      word[idx] <= din;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WORDS; g = g + 1) begin : flat
      assign block[g*14 +: 14] = word[g];
    end
  endgenerate

endmodule

// [verif/nsac_mem_model.sv]
// nsac_mem_model: behavioural flash and eeprom arrays behind the controller
// assumes mem_rd, mem_erase are one-cycle pulses from the controller on pclk
`timescale 1ns/1ps
module nsac_mem_model (
  // clock
  input  wire logic        pclk,
  // array requests
  input  wire logic        mem_prog_space,
  input  wire logic [14:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_erase,
  // answers and records
  output logic      [13:0] mem_rdata,
  output logic      [7:0]  erase_cnt = 8'h00,
  output logic      [14:0] erase_addr = 15'h0000
);
  logic [13:0] junk = 14'h0000;
  // word stands while the read pulse is high, so the controller takes it on the next edge
  assign mem_rdata = !mem_rd ? junk : mem_prog_space ? mem_addr[13:0] ^ 14'h1a5c
    : {6'h00, mem_addr[7:0] ^ 8'hc3};
  always @(posedge pclk) begin
    junk <= ~junk; // toggles outside reads so nothing stale passes
    // one pulse counts one erase and records its address
    if (mem_erase) begin
      erase_cnt <= erase_cnt + 8'h01;
      erase_addr <= mem_addr;
    end
  end
endmodule

// [verif/nsac_chk.sv]
// nsac_chk: port-level assertions for nsac_ctrl
// assumes binding into nsac_ctrl; single pclk domain
`timescale 1ns/1ps
`include "nsac_consts.vh"
module nsac_chk #(
  parameter int ERASE_CYCLES = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        data_protect_fuse,
  input wire logic [1:0]  self_write_protect,
  input wire logic        ext_req,
  input wire logic        ext_grant,
  input wire logic        cpu_halt,
  input wire logic        cpu_discard,
  input wire logic        mem_prog_space,
  input wire logic [14:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_erase,
  input wire logic        mem_write
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] hcnt;
  logic        go_rd;
  // length of the current halt, so the stall can be checked without long repetitions
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hcnt <= 32'h0;
    else
      hcnt <= cpu_halt ? hcnt + 32'h1 : 32'h0;
  end
  // idle program read trigger taken on the bus
  assign go_rd = psel && penable && pready && pwrite && paddr == `NSAC_OFF_CONTROL
    && pwdata[0] && pwdata[7] && !pwdata[6] && !pwdata[1] && !cpu_halt;
  grant_follow_a: assert property ($past(presetn) |->
    ext_grant == ($past(ext_req) && $past(data_protect_fuse))) else $error("grant wrong");
  protect_deny_a: assert property ($past(presetn) && !$past(data_protect_fuse) |->
    !ext_grant) else $error("grant while protected");
  discard_flash_a: assert property (cpu_discard |-> mem_rd && mem_prog_space ##1
    !cpu_discard) else $error("discard not at flash read");
  read_slot_a: assert property (go_rd |-> ##[1:4] (mem_rd && cpu_discard))
    else $error("no flash read slot");
  erase_halt_a: assert property (mem_erase |-> cpu_halt) else $error("erase w/o halt");
  halt_len_a: assert property ($fell(cpu_halt) |-> hcnt >= ERASE_CYCLES
    && hcnt <= ERASE_CYCLES + 2) else $error("halt length wrong");
  wprot_seg_a: assert property ((mem_erase || mem_write) && mem_prog_space |->
    self_write_protect == 2'b11
    || (self_write_protect == 2'b10 && mem_addr >= `NSAC_WRP_LIMIT_SMALL)
    || (self_write_protect == 2'b01 && mem_addr >= `NSAC_WRP_LIMIT_HALF))
    else $error("write in protected segment");
  erase_single_a: assert property (mem_erase |=> !mem_erase [*8])
    else $error("erase repeated");
  halt_noread_a: assert property (cpu_halt |-> !mem_rd) else $error("read during halt");
  cover property (mem_erase);
  cover property (cpu_discard);
  cover property ($fell(cpu_halt));
  cover property (ext_grant);
endmodule
bind nsac_ctrl nsac_chk #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .data_protect_fuse(data_protect_fuse),
  .self_write_protect(self_write_protect), .ext_req(ext_req), .ext_grant(ext_grant),
  .cpu_halt(cpu_halt), .cpu_discard(cpu_discard), .mem_prog_space(mem_prog_space),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_erase(mem_erase), .mem_write(mem_write));

// [verif/nsac_ctrl_test.sv]
// nsac_ctrl_test: random program/eeprom reads, row erases, protection, external grant
// assumes nsac_mem_model as the arrays and nsac_chk bound into the dut
`timescale 1ns/1ps
`include "nsac_consts.vh"
module nsac_ctrl_test;
  localparam int NCYC = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sp;
  logic [7:0]  paddr, erase_cnt, mem_wbyte, wb;
  logic [111:0] mem_wblock, blk;
  logic [31:0] pwdata, prdata, rd;
  logic        data_protect_fuse, program_protect_fuse, ext_req, ext_grant;
  logic [1:0]  self_write_protect;
  logic        cpu_halt, cpu_discard, mem_prog_space, mem_rd, mem_erase, mem_write;
  logic [14:0] mem_addr, erase_addr;
  logic [13:0] mem_rdata, w;
  logic [15:0] a;
  integer      seed, n_mismatch, samples_checked, n_disc, i;
  time         t_go, t_er;
  nsac_ctrl #(.ERASE_CYCLES(NCYC), .WRITE_CYCLES(NCYC)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_protect_fuse(data_protect_fuse), .program_protect_fuse(program_protect_fuse),
    .self_write_protect(self_write_protect), .ext_req(ext_req), .ext_grant(ext_grant),
    .cpu_halt(cpu_halt), .cpu_discard(cpu_discard), .mem_prog_space(mem_prog_space),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_erase(mem_erase),
    .mem_write(mem_write), .mem_wbyte(mem_wbyte), .mem_wblock(mem_wblock));
  nsac_mem_model mem_u (
    .pclk(pclk), .mem_prog_space(mem_prog_space), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_erase(mem_erase), .mem_rdata(mem_rdata), .erase_cnt(erase_cnt),
    .erase_addr(erase_addr));
  // free-running 100 MHz clock
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // mid-cycle sampling keeps clear of edge races
  always @(negedge pclk) begin
    if (mem_erase) t_er = $time;
    if (cpu_discard) n_disc = n_disc + 1;
    if (mem_write) {wb, blk} = {mem_wbyte, mem_wblock};
  end
  function automatic logic [13:0] fw(input logic [14:0] x);
    return x[13:0] ^ 14'h1a5c;
  endfunction
  function automatic logic [7:0] eb(input logic [14:0] x);
    return x[7:0] ^ 8'hc3;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task close_out;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer; waits on pready, bounded
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) n_mismatch++;
    rd = prdata;
    er = pslverr;
    t_go = $time;
    psel <= 0;
    penable <= 0;
  endtask
  // software poll on a self-clearing control bit
  task wait_clr(input int b);
    for (int k = 0; k < 60; k++) begin
      apb(0, `NSAC_OFF_CONTROL, 0);
      if (rd[b] === 1'b0) break;
    end
    chk(rd[b], 0, "control bit stuck");
  endtask
  task erase(input logic [14:0] row, input logic [7:0] c, input logic ok, input logic werr);
    logic [7:0] n0;
    time        t0;
    n0 = erase_cnt;
    apb(1, `NSAC_OFF_ADDR_LOW, {24'h0, row[7:0]});
    apb(1, `NSAC_OFF_ADDR_HIGH, {25'h0, row[14:8]});
    apb(1, `NSAC_OFF_CONTROL, {24'h0, c});
    apb(1, `NSAC_OFF_UNLOCK_KEY, {24'h0, `NSAC_KEY_FIRST});
    apb(1, `NSAC_OFF_UNLOCK_KEY, {24'h0, `NSAC_KEY_SECOND});
    apb(1, `NSAC_OFF_CONTROL, {24'h0, c | 8'h02});
    t0 = t_go;
    if (ok) begin
      apb(0, `NSAC_OFF_CONTROL, 0);
      chk(rd[5], 1, "erase select low");
      apb(1, `NSAC_OFF_CONTROL, 32'h0000_00a0);  // permit dropped must not abort
    end
    wait_clr(`NSAC_CTL_PROGRAM_GO);
    chk(erase_cnt, n0 + ok, "erase count");
    if (ok) begin
      chk(32'((t_er - t0) / 10), 2, "erase start");
      chk(erase_addr[14:5], row[14:5], "erase row");
      chk(rd[5], 0, "erase select stuck");
      apb(0, `NSAC_OFF_FLAGS, 0);
      chk(rd[`NSAC_FLG_DONE], 1, "no done flag");
      apb(1, `NSAC_OFF_FLAGS, 1);
      apb(0, `NSAC_OFF_FLAGS, 0);
      chk(rd[`NSAC_FLG_DONE], 0, "done not cleared");
    end else
      chk(rd[`NSAC_CTL_WRITE_ERROR], werr, "write error");
  endtask
  // watchdog: whole run needs well under 5000 cycles
  initial begin
    #300000;
    n_mismatch++;
    close_out;
  end
  initial begin
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    {data_protect_fuse, program_protect_fuse, ext_req} = 3'b100;
    self_write_protect = 2'b11;
    seed = 18488;
    n_mismatch = 0;
    samples_checked = 0;
    n_disc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(mem_prog_space, 0, "space after reset");
    apb(0, `NSAC_OFF_CONTROL, 0);
    chk(rd, `NSAC_CONTROL_RESET, "control reset");
    apb(0, 8'h20, 0);
    chk(er, 1, "unmapped offset");
    for (i = 0; i < 2; i++) begin
      @(posedge pclk);
      data_protect_fuse <= i[0];
      program_protect_fuse <= i[0];
      ext_req <= 1;
      repeat (3) @(posedge pclk);
      chk(ext_grant, i, "external grant");
    end
    ext_req <= 0;
    // random reads, flash first with the top address as a corner, then eeprom
    for (i = 0; i < 8; i++) begin
      a = (i == 0) ? 16'h7fff : 16'($random(seed));
      sp = (i < 6);
      program_protect_fuse <= a[15];
      w = sp ? fw(a[14:0]) : {6'h00, eb(a[14:0])};
      apb(1, `NSAC_OFF_ADDR_LOW, {24'h0, a[7:0]});
      apb(1, `NSAC_OFF_ADDR_HIGH, {25'h0, a[14:8]});
      apb(1, `NSAC_OFF_CONTROL, {24'h0, sp, 7'h00});
      n_disc = 0;
      apb(1, `NSAC_OFF_CONTROL, {24'h0, sp, 7'h01});
      wait_clr(`NSAC_CTL_READ_TRIGGER);
      chk(n_disc, sp, "discard count");
      apb(0, `NSAC_OFF_DATA_LOW, 0);
      chk(rd, {24'h0, w[7:0]}, "read low");
      apb(0, `NSAC_OFF_DATA_HIGH, 0);
      if (sp) chk(rd, {26'h0, w[13:8]}, "read high");
      chk(mem_prog_space, sp, "space select");
    end
    self_write_protect <= 2'b10;
    erase(15'h1240, 8'ha0, 0, 0);
    erase(15'h01e0, 8'ha4, 0, 1);
    erase(15'h0200, 8'ha4, 1, 0);
    // eeprom byte write, then one latch word programmed as a block
    erase({7'h00, a[7:0]}, 8'h04, 0, 0);
    chk(wb, w[7:0], "eeprom byte");
    erase({7'h12, a[7:0]}, 8'h84, 0, 0);
    chk(blk[a[2:0]*14 +: 14], w, "latch word");
    chk(mem_addr, {7'h12, a[7:3], 3'b000}, "block address");
    chk(mem_wblock[a[2:0]*14 +: 14], `NSAC_LATCH_BLANK, "latch not blanked");
    close_out;
  end
endmodule
